// ==== hw/lbx_pkg.sv ====
package lbx_pkg;

   localparam int unsigned OPC_W = 4;
   localparam int unsigned ADDR_W_DEF = 12;
   localparam int unsigned BIT_ADDR_W_DEF = 14;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned BIT_FIELD_W = 12;

   // opcode field sits in the top nibble of the first word
   localparam int unsigned OPC_LSB = 12;
   localparam logic [OPC_W-1:0] OPC_NOP = 4'h0;
   localparam logic [OPC_W-1:0] OPC_LOAD = 4'h1;
   localparam logic [OPC_W-1:0] OPC_LOAD_INV = 4'h2;
   localparam logic [OPC_W-1:0] OPC_AND = 4'h3;
   localparam logic [OPC_W-1:0] OPC_AND_INV = 4'h4;
   localparam logic [OPC_W-1:0] OPC_OR = 4'h5;
   localparam logic [OPC_W-1:0] OPC_OR_INV = 4'h6;
   localparam logic [OPC_W-1:0] OPC_OUT = 4'h7;
   localparam logic [OPC_W-1:0] OPC_OUT_INV = 4'h8;
   localparam logic [OPC_W-1:0] OPC_END = 4'hF;

   // extra operand words for opcodes outside this unit; bits 11:10 of word 0
   localparam int unsigned EXTRA_LSB = 10;

   localparam logic [15:0] PROG_START_ADDR = 16'h0000;
   localparam logic COND_RESET = 1'b0;

   typedef struct packed {
      logic [OPC_W-1:0] opcode;
      logic [BIT_FIELD_W-1:0] bit_addr;
   } lbx_instr_s;

   typedef struct packed {
      logic req;
      logic we;
      logic wdata;
   } lbx_bit_req_s;

endpackage

// ==== hw/lbx_decode.sv ====
`timescale 1ns/1ps
module lbx_decode (
   input wire logic [15:0] word0,
   output lbx_pkg::lbx_instr_s instr,
   output logic [2:0] length,
   output logic is_logic,
   output logic is_out,
   output logic is_end,
   output logic uses_bit
);
   always_comb begin
      instr.opcode = word0[lbx_pkg::OPC_LSB +: lbx_pkg::OPC_W];
      instr.bit_addr = word0[lbx_pkg::BIT_FIELD_W-1:0];
      is_logic = 1'b0;
      is_out = 1'b0;
      is_end = 1'b0;
      uses_bit = 1'b0;
      length = 3'h1;
      case (instr.opcode)
         lbx_pkg::OPC_LOAD, lbx_pkg::OPC_LOAD_INV, lbx_pkg::OPC_AND, lbx_pkg::OPC_AND_INV,
         lbx_pkg::OPC_OR, lbx_pkg::OPC_OR_INV: begin
            is_logic = 1'b1;
            uses_bit = 1'b1;
         end
         lbx_pkg::OPC_OUT, lbx_pkg::OPC_OUT_INV: begin
            is_out = 1'b1;
            uses_bit = 1'b1;
         end
         lbx_pkg::OPC_END: begin
            is_end = 1'b1;
         end
         default: begin
            // other instructions are skipped over, one to four words long
            length = {1'b0, word0[lbx_pkg::EXTRA_LSB +: 2]} + 3'h1;
         end
      endcase
   end
endmodule

// ==== hw/lbx_executor.sv ====
`timescale 1ns/1ps
module lbx_executor #(
   parameter int unsigned ADDR_W = lbx_pkg::ADDR_W_DEF,
   parameter int unsigned BIT_ADDR_W = lbx_pkg::BIT_ADDR_W_DEF
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic run_enable,
   output logic [ADDR_W-1:0] prog_addr,
   output logic prog_rd,
   input wire logic [15:0] prog_rdata,
   output logic [BIT_ADDR_W-1:0] bit_addr,
   output logic bit_req,
   output logic bit_we,
   output logic bit_wdata,
   input wire logic bit_rdata,
   output logic exec_cond,
   output logic running,
   output logic no_end_fault,
   output logic scan_done
);

   // the wrap test and the operand field cannot serve other widths
   if (ADDR_W < 4 || ADDR_W > 16) begin : g_bad_addr_w
      $error("lbx_executor: unsupported program address width");
   end
   if (BIT_ADDR_W < lbx_pkg::BIT_FIELD_W || BIT_ADDR_W > 24) begin : g_bad_bit_addr_w
      $error("lbx_executor: unsupported bit address width");
   end

   ////////////////////////////////////////////////////////////////////////////
   typedef enum {
      ST_CHECK_FETCH,
      ST_CHECK_WAIT,
      ST_HALT,
      ST_FETCH,
      ST_WAIT,
      ST_DECODE,
      ST_BIT_WAIT,
      ST_EXEC
   } lbx_state_e;

   lbx_state_e state_reg, state_next;
   logic [ADDR_W-1:0] pc_reg, pc_next;
   logic [15:0] word_reg, word_next;
   logic cond_reg, cond_next;
   logic fault_reg, fault_next;
   logic done_reg, done_next;
   lbx_pkg::lbx_bit_req_s breq_reg, breq_next;
   logic [BIT_ADDR_W-1:0] baddr_reg, baddr_next;
   logic rd_reg, rd_next;

   lbx_pkg::lbx_instr_s instr;
   logic [2:0] ilen;
   logic is_logic;
   logic is_out;
   logic is_end;
   logic uses_bit;
   logic [2:0] cur_len;
   logic [ADDR_W-1:0] pc_step;
   logic pc_last;

   lbx_decode lbx_decode_inst (
      .word0(word_reg),
      .instr(instr),
      .length(ilen),
      .is_logic(is_logic),
      .is_out(is_out),
      .is_end(is_end),
      .uses_bit(uses_bit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // pre-scan looks for a terminator once, so a program without one never runs
   // decoded step events
   logic at_decode;
   logic end_in_check;
   logic end_in_run;
   logic bit_issue;
   logic fetch_go;
   logic cond_update;
   logic halt_reg;
   logic halt_next;

   // step decisions shared by the groups below
   assign cur_len = ilen;
   assign pc_step = pc_reg + ADDR_W'(cur_len);
   // a step past the top would wrap to zero and rescan without end
   assign pc_last = (pc_step < pc_reg) || (pc_reg == '1);
   assign at_decode = (state_reg == ST_DECODE);
   assign end_in_check = at_decode && fault_reg && is_end;
   assign end_in_run = at_decode && !fault_reg && is_end;
   assign bit_issue = at_decode && !fault_reg && !is_end && uses_bit;
   assign fetch_go = (state_reg == ST_CHECK_FETCH) || (state_reg == ST_FETCH && run_enable);
   assign cond_update = (state_reg == ST_EXEC) && is_logic;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer: state, program counter and instruction word
   always_comb begin
      state_next = state_reg;
      pc_next = pc_reg;
      word_next = word_reg;
      case (state_reg)
         ST_CHECK_FETCH: begin
            state_next = ST_CHECK_WAIT;
         end
         ST_CHECK_WAIT: begin
            word_next = prog_rdata;
            state_next = ST_DECODE;
         end
         ST_HALT: begin
            // only a reset leaves this state
            state_next = ST_HALT;
         end
         ST_FETCH: begin
            // a low run_enable parks the scan between instructions
            if (run_enable) begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            word_next = prog_rdata;
            state_next = ST_DECODE;
         end
         ST_DECODE: begin
            if (fault_reg) begin
               // checking pass: only the terminator search matters
               if (is_end) begin
                  pc_next = ADDR_W'(lbx_pkg::PROG_START_ADDR);
                  state_next = ST_FETCH;
               end else if (pc_last) begin
                  state_next = ST_HALT;
               end else begin
                  pc_next = pc_step;
                  state_next = ST_CHECK_FETCH;
               end
            end else if (is_end) begin
               // terminator wraps before anything past it is read
               pc_next = ADDR_W'(lbx_pkg::PROG_START_ADDR);
               state_next = ST_FETCH;
            end else if (uses_bit && !is_out) begin
               state_next = ST_BIT_WAIT;
            end else begin
               // outputs and skipped opcodes step on at once
               pc_next = pc_step;
               state_next = ST_FETCH;
            end
         end
         ST_BIT_WAIT: begin
            // bit memory answers one cycle after the request
            state_next = ST_EXEC;
         end
         ST_EXEC: begin
            pc_next = pc_step;
            state_next = ST_FETCH;
         end
         default: begin
            state_next = ST_HALT;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_CHECK_FETCH;
         pc_reg <= ADDR_W'(lbx_pkg::PROG_START_ADDR);
         word_reg <= '0;
      end else begin
         state_reg <= state_next;
         pc_reg <= pc_next;
         word_reg <= word_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status: fault stays set until a terminator is found
   // halt flag taken from the next state so the pin comes from a flop
   always_comb begin
      fault_next = fault_reg;
      done_next = 1'b0;
      halt_next = (state_next == ST_HALT);
      if (state_reg == ST_HALT) begin
         fault_next = 1'b1;
      end else if (end_in_check) begin
         fault_next = 1'b0;
      end
      if (end_in_run) begin
         done_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         fault_reg <= 1'b1;
         done_reg <= 1'b0;
         halt_reg <= 1'b0;
      end else begin
         fault_reg <= fault_next;
         done_reg <= done_next;
         halt_reg <= halt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fetch strobe: one cycle per word
   // registered so the address is already settled under it
   always_comb begin
      rd_next = 1'b0;
      if (fetch_go) begin
         rd_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rd_reg <= 1'b0;
      end else begin
         rd_reg <= rd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // condition: one update per logic instruction, result carried forward
   always_comb begin
      cond_next = cond_reg;
      if (cond_update) begin
         case (instr.opcode)
            lbx_pkg::OPC_LOAD: cond_next = bit_rdata;
            lbx_pkg::OPC_LOAD_INV: cond_next = ~bit_rdata;
            lbx_pkg::OPC_AND: cond_next = cond_reg & bit_rdata;
            lbx_pkg::OPC_AND_INV: cond_next = cond_reg & ~bit_rdata;
            lbx_pkg::OPC_OR: cond_next = cond_reg | bit_rdata;
            lbx_pkg::OPC_OR_INV: cond_next = cond_reg | ~bit_rdata;
            default: cond_next = cond_reg;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cond_reg <= lbx_pkg::COND_RESET;
      end else begin
         cond_reg <= cond_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit port: one request per bit instruction
   // a write issued here lands before any later read of the same bit
   always_comb begin
      breq_next = '0;
      baddr_next = baddr_reg;
      if (bit_issue) begin
         baddr_next = BIT_ADDR_W'(instr.bit_addr);
         breq_next.req = 1'b1;
         if (is_out) begin
            breq_next.we = 1'b1;
            breq_next.wdata = (instr.opcode == lbx_pkg::OPC_OUT) ? cond_reg : ~cond_reg;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         breq_reg <= '0;
         baddr_reg <= '0;
      end else begin
         breq_reg <= breq_next;
         baddr_reg <= baddr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // single synchronous port: write lands before the next fetch completes
   assign prog_addr = pc_reg;
   assign prog_rd = rd_reg;
   assign bit_addr = baddr_reg;
   assign bit_req = breq_reg.req;
   assign bit_we = breq_reg.we;
   assign bit_wdata = breq_reg.wdata;
   assign exec_cond = cond_reg;
   assign running = ~fault_reg;
   assign no_end_fault = halt_reg;
   assign scan_done = done_reg;

endmodule

// ==== verif/lbx_executor_chk.sv ====
`timescale 1ns/1ps
module lbx_executor_chk #(
   parameter int unsigned ADDR_W = lbx_pkg::ADDR_W_DEF,
   parameter int unsigned BIT_ADDR_W = lbx_pkg::BIT_ADDR_W_DEF
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic run_enable,
   input wire logic [ADDR_W-1:0] prog_addr,
   input wire logic prog_rd,
   input wire logic [15:0] prog_rdata,
   input wire logic [BIT_ADDR_W-1:0] bit_addr,
   input wire logic bit_req,
   input wire logic bit_we,
   input wire logic bit_wdata,
   input wire logic bit_rdata,
   input wire logic exec_cond,
   input wire logic running,
   input wire logic no_end_fault,
   input wire logic scan_done
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_rd_pulse; prog_rd |=> !prog_rd; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
   property p_start_zero; $rose(running) |-> ##[0:6] (prog_rd && prog_addr == '0); endproperty
   a_start_zero: assert property (p_start_zero) else $error("run not started at zero");
   property p_fault_idle; no_end_fault |-> !running && !bit_req; endproperty
   a_fault_idle: assert property (p_fault_idle) else $error("executing without terminator");
   property p_fault_hold; no_end_fault |=> no_end_fault; endproperty
   a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
   property p_done_pulse; scan_done |=> !scan_done; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("scan end pulse too long");
   property p_restart; scan_done |-> ##[0:8] (prog_rd && prog_addr == '0); endproperty
   a_restart: assert property (p_restart) else $error("scan not restarted at zero");
   property p_run_hold; running |=> running && !no_end_fault; endproperty
   a_run_hold: assert property (p_run_hold) else $error("run stopped");
   property p_cond_src; !$stable(exec_cond) |-> $past(bit_req && !bit_we, 2); endproperty
   a_cond_src: assert property (p_cond_src) else $error("condition moved without bit read");
endmodule
bind lbx_executor lbx_executor_chk #(.ADDR_W(ADDR_W), .BIT_ADDR_W(BIT_ADDR_W)) lbx_executor_chk_inst (.*);

// ==== verif/lbx_mem_model.sv ====
`timescale 1ns/1ps
module lbx_mem_model #(
   parameter int unsigned AW = 6
) (
   input wire logic clk_sys,
   input wire logic [AW-1:0] prog_addr,
   input wire logic prog_rd,
   output logic [15:0] prog_rdata,
   input wire logic [13:0] bit_addr,
   input wire logic bit_req,
   input wire logic bit_we,
   input wire logic bit_wdata,
   output logic bit_rdata
);
   logic [15:0] prog [2**AW];
   logic bits [64];
   logic [1:0] hold = 2'h0;
   // word stands only while the strobe is up, otherwise its inverse shows
   assign prog_rdata = prog_rd ? prog[prog_addr] : ~prog[prog_addr];
   initial bit_rdata = 1'b0;
   always @(posedge clk_sys) begin
      if (bit_req && bit_we) begin
         bits[bit_addr[5:0]] <= bit_wdata;
      end
      if (bit_req && !bit_we) begin
         bit_rdata <= bits[bit_addr[5:0]];
         hold <= 2'h2;
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
      end else begin
         bit_rdata <= ~bit_rdata;
      end
   end
endmodule

// ==== verif/ladder_bit_logic_executor_bench.sv ====
`timescale 1ns/1ps
module ladder_bit_logic_executor_bench;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic run_enable = 1'b1;
   logic [5:0] prog_addr;
   logic prog_rd;
   logic [15:0] prog_rdata;
   logic [13:0] bit_addr;
   logic bit_req, bit_we, bit_wdata, bit_rdata;
   logic exec_cond, running, no_end_fault, scan_done;
   int fail_count = 0;
   int check_count = 0;
   always #4 clk_sys = ~clk_sys;
   lbx_executor #(.ADDR_W(6)) lbx_executor_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .run_enable(run_enable),
      .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata), .bit_addr(bit_addr), .bit_req(bit_req),
      .bit_we(bit_we), .bit_wdata(bit_wdata), .bit_rdata(bit_rdata), .exec_cond(exec_cond), .running(running),
      .no_end_fault(no_end_fault), .scan_done(scan_done));
   lbx_mem_model #(.AW(6)) lbx_mem_model_inst (.clk_sys(clk_sys), .prog_addr(prog_addr), .prog_rd(prog_rd),
      .prog_rdata(prog_rdata), .bit_addr(bit_addr), .bit_req(bit_req), .bit_we(bit_we), .bit_wdata(bit_wdata),
      .bit_rdata(bit_rdata));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(string what, logic got, logic exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic reset_on;
      @(posedge clk_sys);
      sys_rst <= 1'b1;
   endtask
   task automatic reset_off;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
   endtask
   task automatic wait_scans(int n);
      int k;
      k = 0;
      for (int i = 0; i < 4000 && k < n; i++) begin
         @(posedge clk_sys);
         #1;
         if (scan_done === 1'b1) k++;
      end
      check("scan_done", k >= n, 1'b1);
      if (k < n) test_done();
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic test_logic;
      // word = opcode nibble, bit operand; 9400 is foreign with one extra word
      logic [15:0] words [25] = '{16'h1000, 16'h700A, 16'h2000, 16'h700B, 16'h1000, 16'h3001, 16'h700C,
         16'h1000, 16'h4001, 16'h700D, 16'h1001, 16'h5000, 16'h700E, 16'h1001, 16'h6000, 16'h800F,
         16'h100A, 16'h4000, 16'h5002, 16'h7010, 16'h9400, 16'h7011, 16'hF000, 16'h1000, 16'h7014};
      logic [7:0] exp = 8'b01111001;
      reset_on();
      foreach (lbx_mem_model_inst.prog[i]) lbx_mem_model_inst.prog[i] = 16'h0000;
      foreach (words[i]) lbx_mem_model_inst.prog[i] = words[i];
      lbx_mem_model_inst.bits[0] = 1'b1;
      lbx_mem_model_inst.bits[1] = 1'b0;
      lbx_mem_model_inst.bits[2] = 1'b1;
      lbx_mem_model_inst.bits[20] = 1'b0;
      // outputs start opposite to the result so a missed write shows
      for (int i = 0; i < 8; i++) lbx_mem_model_inst.bits[10+i] = ~exp[i];
      lbx_mem_model_inst.bits[17] = 1'b0;
      reset_off();
      wait_scans(2);
      for (int i = 0; i < 8; i++) check("out bit", lbx_mem_model_inst.bits[10+i], exp[i]);
      check("after end", lbx_mem_model_inst.bits[20], 1'b0);
      check("running", running, 1'b1);
      check("exec_cond", exec_cond, 1'b1);
      lbx_mem_model_inst.bits[0] = 1'b0;
      wait_scans(2);
      check("rescan load", lbx_mem_model_inst.bits[10], 1'b0);
      check("rescan inv", lbx_mem_model_inst.bits[11], 1'b1);
   endtask
   task automatic test_noend;
      int i;
      reset_on();
      foreach (lbx_mem_model_inst.prog[j]) lbx_mem_model_inst.prog[j] = j[0] ? 16'h7014 : 16'h1000;
      lbx_mem_model_inst.bits[0] = 1'b0;
      lbx_mem_model_inst.bits[20] = 1'b1;
      reset_off();
      for (i = 0; i < 600 && no_end_fault !== 1'b1; i++) @(posedge clk_sys);
      repeat (50) @(posedge clk_sys);
      check("no_end_fault", no_end_fault, 1'b1);
      check("running", running, 1'b0);
      check("untouched bit", lbx_mem_model_inst.bits[20], 1'b1);
   endtask
   initial begin
      test_logic();
      test_noend();
      test_done();
   end
endmodule
